// ---- rtl/mmd_core_map.sv ----
// program counter, stack, data map, timer, port and wake logic of the core
// How it works
// - ten bit pc reaches all 1K words
// - reset loads pc with last address
// - hardware interrupt jumps to 0x008
// - software interrupt jumps to 0x002
// - jumps and calls carry full address
// - five deep return stack for calls
// - flow changes cost a second cycle
// - ram reached directly and through pointer
// - sfrs low, byte 0x07, ram 0x10-0x3f
// - unimplemented bits read fixed zero or one
// - option and direction loaded by instructions
// - pin 3 low resets, pull-up forced on only outside reset
// - pin 3 never drives high
// - pin 4 may output instruction clock
// - pin 5 clock input in external_res_osc mode
// - pin 2 may clock the timer
// - eight bit timer with prescaler
// - timer, ext pin, port change interrupts
// - ext pin or change wakes sleep
// - watchdog on own tick, enabled from reset, software can turn it off
// - each pin has own direction
// - pointer low six bits address data
// - pointer at port itself reads zero
`timescale 1ns/10ps
module mmd_core_map
   import mmd_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // program flow from the core
   input wire mmd_flow_t flow_i,
   output logic [9:0] pc_o,
   output logic instr_valid_o,
   // data access from the core
   input wire mmd_dacc_t dacc_i,
   input wire logic flags_we_i,
   input wire logic [2:0] flags_i,
   output logic [7:0] rdata_o,
   // dedicated instructions
   input wire logic option_load_i,
   input wire logic dir_load_i,
   input wire logic [5:0] dir_sel_i,
   input wire logic sleep_i,
   input wire logic clrwdt_i,
   // configuration straps
   input wire logic [1:0] osc_mode_i,
   input wire logic pin3_is_reset_i,
   input wire logic pin4_clkout_en_i,
   // watchdog oscillator tick
   input wire logic wdt_tick_i,
   // port pins
   input wire logic [5:0] pin_in_i,
   output logic [5:0] pin_out_o,
   output logic [5:0] pin_oe_o,
   output logic [5:0] pull_up_o,
   output logic [5:0] pull_down_o,
   // events to the core
   output logic irq_req_o,
   output logic wake_o,
   output logic sleeping_o,
   output logic wdt_timeout_o
);
   // ------------ reset
   logic sys_rst;
   assign sys_rst = rst_i | (pin3_is_reset_i & ~pin_in_i[3]);

   function automatic logic [5:0] eff_addr(input logic [5:0] a,
                                           input logic [7:0] ptr);
      eff_addr = (a == A_INDIRECT) ? ptr[5:0] : a;
   endfunction

   // ------------ state
   logic [9:0] pc_r, pc_nxt;
   mmd_ex_t ex_r, ex_nxt;
   logic [9:0] stk_r [STK_D];
   logic [2:0] depth_r;
   logic [7:0] tmr_r, pre_r, opt_r, ptr_r, pwr_r, ien_r, status_r;
   logic [2:0] ifl_r;
   logic [1:0] pc_high_buffer_r;
   logic [5:0] latch_r, dir_r, wake_en_r, pdn_r, odr_r, pup_r;
   logic [7:0] byte7_r;
   logic [7:0] gpr_r [A_GPR_LO:A_GPR_HI];
   logic [7:0] rdata_r;
   logic [5:0] pin_prev_r;
   logic [5:0] pin_out_r, pin_oe_r, pull_up_r, pull_down_r;
   logic clk_tog_r, irq_r, wake_r, sleep_r;
   logic [WDT_W-1:0] wdt_r;
   logic wdt_to_r;

   // ------------ data decode
   logic [5:0] ea;
   logic wr_ok, rd_self;
   logic is_gpr;
   assign ea = eff_addr(dacc_i.addr, ptr_r);
   assign is_gpr = ea >= A_GPR_LO;
   // a write that points the pointer at the port itself stores nothing
   assign wr_ok = dacc_i.wr & (ea != A_INDIRECT) & (ex_r == MMD_RUN);
   assign rd_self = dacc_i.addr == A_INDIRECT && ea == A_INDIRECT;

   logic [7:0] rd_val;
   always_comb
   begin
      rd_val = 8'h00;
      if (is_gpr)
      begin
         rd_val = gpr_r[ea];
      end
      else
      begin
         unique case (ea)
            A_TIMER: rd_val = tmr_r;
            A_PCL: rd_val = pc_r[7:0];
            A_STATUS: rd_val = status_r & ~8'h60;
            A_POINTER: rd_val = ptr_r | PTR_ONES;
            A_PORT: rd_val = {2'b00, pin_in_i};
            A_BYTE7: rd_val = byte7_r;
            A_PWR: rd_val = pwr_r | PWR_ONES;
            A_WAKE: rd_val = {2'b00, wake_en_r};
            A_PC_HIGH_BUFFER: rd_val = {6'h00, pc_high_buffer_r};
            A_PDN: rd_val = {2'b00, pdn_r};
            A_ODR: rd_val = {2'b00, odr_r};
            A_PUP: rd_val = {2'b00, pup_r};
            A_IEN: rd_val = ien_r | IEN_ONES;
            A_IFL: rd_val = {5'h00, ifl_r};
            default: rd_val = 8'h00;
         endcase
      end
   end

   logic wsel_pcl;
   assign wsel_pcl = wr_ok && ea == A_PCL;

   // ------------ program flow
   logic flow_chg, push;
   assign flow_chg = (ex_r == MMD_RUN) & (flow_i.go | flow_i.call |
                     flow_i.ret | flow_i.hw_irq | flow_i.sw_irq | wsel_pcl);
   assign push = (ex_r == MMD_RUN) &
                 (flow_i.call | flow_i.hw_irq | flow_i.sw_irq);

   always_comb
   begin
      pc_nxt = pc_r + 10'd1;
      ex_nxt = MMD_RUN;
      if (flow_chg)
      begin
         ex_nxt = MMD_BUB;
         if (flow_i.hw_irq)
            pc_nxt = MMD_HWI_VEC;
         else if (flow_i.sw_irq)
            pc_nxt = MMD_SWI_VEC;
         else if (flow_i.ret)
            pc_nxt = stk_r[0];
         else if (wsel_pcl)
            pc_nxt = {pc_high_buffer_r, dacc_i.wdata};
         else
            pc_nxt = flow_i.target;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
      begin
         pc_r <= MMD_RESET_VEC;
         ex_r <= MMD_RUN;
         depth_r <= 3'd0;
      end
      else
      begin
         pc_r <= pc_nxt;
         ex_r <= ex_nxt;
         if (push && depth_r != 3'(STK_D))
            depth_r <= depth_r + 3'd1;
         else if (flow_chg && flow_i.ret && depth_r != 3'd0)
            depth_r <= depth_r - 3'd1;
      end
   end

   // the stack shifts; overflow silently drops the oldest entry
   always_ff @(posedge core_clk_i)
   begin
      if (push)
      begin
         stk_r[0] <= pc_r;
         for (int i = 1; i < STK_D; i++)
            stk_r[i] <= stk_r[i-1];
      end
      else if (flow_chg && flow_i.ret)
      begin
         for (int i = 0; i < STK_D-1; i++)
            stk_r[i] <= stk_r[i+1];
      end
   end

   // ------------ timer and prescaler
   logic pin2_edge, src_tick, pre_hit, tmr_tick, tmr_wr, tmr_ovf;
   logic [7:0] pre_mask;
   assign pin2_edge = opt_r[OPT_SE] ? (pin_prev_r[2] & ~pin_in_i[2])
                                   : (~pin_prev_r[2] & pin_in_i[2]);
   assign src_tick = opt_r[OPT_SRC] ? pin2_edge : 1'b1;
   assign pre_mask = 8'((9'h2 << opt_r[2:0]) - 9'h1);
   assign pre_hit = (pre_r & pre_mask) == pre_mask;
   assign tmr_tick = src_tick & (opt_r[OPT_PSA] | pre_hit);
   assign tmr_wr = wr_ok && ea == A_TIMER;
   assign tmr_ovf = tmr_tick & ~tmr_wr & (tmr_r == 8'hff);

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
      begin
         tmr_r <= 8'h00;
         pre_r <= 8'h00;
         opt_r <= OPT_RST;
      end
      else
      begin
         if (option_load_i)
            opt_r <= dacc_i.wdata;
         if (tmr_wr)
         begin
            tmr_r <= dacc_i.wdata;
            pre_r <= 8'h00;
         end
         else
         begin
            if (tmr_tick)
               tmr_r <= tmr_r + 8'd1;
            if (src_tick && !opt_r[OPT_PSA])
               pre_r <= pre_hit ? 8'h00 : pre_r + 8'd1;
         end
      end
   end

   // ------------ interrupt and wake events
   logic eis, ext_edge, chg_evt, ext_evt;
   logic [5:0] chg_mask;
   logic [2:0] ifl_set, ifl_base;
   assign eis = pwr_r[PWR_EIS];
   assign ext_edge = opt_r[OPT_EDGE] ? (~pin_prev_r[0] & pin_in_i[0])
                                    : (pin_prev_r[0] & ~pin_in_i[0]);
   assign ext_evt = eis & ext_edge;
   // with the ext function on pin 0 its change path is masked
   assign chg_mask = wake_en_r & {5'h1f, ~eis};
   assign chg_evt = |((pin_prev_r ^ pin_in_i) & chg_mask);
   assign ifl_set = {ext_evt, chg_evt, tmr_ovf};
   assign ifl_base = (wr_ok && ea == A_IFL) ? dacc_i.wdata[2:0] : ifl_r;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
      begin
         ifl_r <= 3'h0;
         irq_r <= 1'b0;
         sleep_r <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         ifl_r <= ifl_base | ifl_set;
         irq_r <= ien_r[IEN_GIE] & |(ifl_r & ien_r[2:0]);
         wake_r <= sleep_r & (ext_evt | chg_evt);
         if (sleep_r && (ext_evt || chg_evt))
            sleep_r <= 1'b0;
         else if (sleep_i)
            sleep_r <= 1'b1;
      end
   end

   // ------------ watchdog
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
      begin
         wdt_r <= '0;
         wdt_to_r <= 1'b0;
      end
      else
      begin
         wdt_to_r <= 1'b0;
         if (clrwdt_i || sleep_i || !pwr_r[PWR_WDE])
            wdt_r <= '0;
         else if (wdt_tick_i)
         begin
            wdt_r <= wdt_r + WDT_W'(1);
            wdt_to_r <= &wdt_r;
         end
      end
   end

   // ------------ register file writes
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
      begin
         ptr_r <= 8'h00;
         pwr_r <= PWR_RST;
         ien_r <= 8'h00;
         pc_high_buffer_r <= 2'b00;
         latch_r <= 6'h00;
         dir_r <= DIR_RST;
         wake_en_r <= 6'h00;
         pdn_r <= 6'h3f;
         odr_r <= 6'h00;
         pup_r <= 6'h3f;
         byte7_r <= 8'h00;
      end
      else
      begin
         if (dir_load_i && dir_sel_i == A_DIR_SEL)
            dir_r <= dacc_i.wdata[5:0];
         if (wr_ok)
         begin
            unique case (ea)
               A_POINTER: ptr_r <= dacc_i.wdata;
               A_PORT: latch_r <= dacc_i.wdata[5:0];
               A_BYTE7: byte7_r <= dacc_i.wdata;
               A_PWR: pwr_r <= dacc_i.wdata & ~PWR_ONES;
               A_WAKE: wake_en_r <= dacc_i.wdata[5:0];
               A_PC_HIGH_BUFFER: pc_high_buffer_r <= dacc_i.wdata[1:0];
               A_PDN: pdn_r <= dacc_i.wdata[5:0];
               A_ODR: odr_r <= dacc_i.wdata[5:0];
               A_PUP: pup_r <= dacc_i.wdata[5:0];
               A_IEN: ien_r <= dacc_i.wdata & ~IEN_ONES;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (wr_ok && is_gpr)
         gpr_r[ea] <= dacc_i.wdata;
   end

   // status: alu flags win over a software write
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
         status_r <= STATUS_RST;
      else
      begin
         if (wr_ok && ea == A_STATUS)
            status_r <= (status_r & ~STATUS_WMASK) |
                        (dacc_i.wdata & STATUS_WMASK);
         if (flags_we_i)
            status_r[2:0] <= flags_i;
         if (sleep_r && chg_evt)
            status_r[ST_RST] <= 1'b1;
         if (clrwdt_i)
         begin
            status_r[ST_TO] <= 1'b1;
            status_r[ST_PD] <= 1'b1;
         end
         else if (sleep_i)
         begin
            status_r[ST_TO] <= 1'b1;
            status_r[ST_PD] <= 1'b0;
         end
         if (wdt_to_r)
            status_r[ST_TO] <= 1'b0;
      end
   end

   // ------------ read data
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
         rdata_r <= 8'h00;
      else if (dacc_i.rd)
         rdata_r <= rd_self ? 8'h00 : rd_val;
   end

   // ------------ pins
   logic [5:0] drive, oe_nxt, out_nxt, pu_nxt;
   logic clk_out_on, external_res_osc;
   assign external_res_osc = osc_mode_i == OSC_EXTERNAL_RES_OSC;
   assign clk_out_on = pin4_clkout_en_i &
                       (osc_mode_i == OSC_IRC || external_res_osc);
   // open drain pins only pull low; pin 3 is always open drain
   assign drive = ~dir_r & ~((odr_r | 6'h08) & latch_r);
   always_comb
   begin
      oe_nxt = drive;
      out_nxt = latch_r & ~6'h08;
      pu_nxt = ~pup_r;
      if (pin3_is_reset_i)
      begin
         oe_nxt[3] = 1'b0;
         pu_nxt[3] = 1'b1;
      end
      if (clk_out_on)
      begin
         oe_nxt[4] = 1'b1;
         out_nxt[4] = clk_tog_r;
      end
      if (external_res_osc)
         oe_nxt[5] = 1'b0;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst)
      begin
         // seeded with the live pins so release shows no false edge
         pin_prev_r <= pin_in_i;
         pin_out_r <= 6'h00;
         pin_oe_r <= 6'h00;
         pull_up_r <= 6'h00;
         pull_down_r <= 6'h00;
         clk_tog_r <= 1'b0;
      end
      else
      begin
         pin_prev_r <= pin_in_i;
         pin_out_r <= out_nxt;
         pin_oe_r <= oe_nxt;
         pull_up_r <= pu_nxt;
         pull_down_r <= ~pdn_r & 6'h07;
         clk_tog_r <= ~clk_tog_r;
      end
   end

   assign pc_o = pc_r;
   assign instr_valid_o = ex_r == MMD_RUN;
   assign rdata_o = rdata_r;
   assign pin_out_o = pin_out_r;
   assign pin_oe_o = pin_oe_r;
   assign pull_up_o = pull_up_r;
   assign pull_down_o = pull_down_r;
   assign irq_req_o = irq_r;
   assign wake_o = wake_r;
   assign sleeping_o = sleep_r;
   assign wdt_timeout_o = wdt_to_r;

   // ------------ checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst);

   a_reset_vector: assert property (
      $fell(sys_rst) |-> pc_o == MMD_RESET_VEC)
      else $error("pc not at reset vector");
   a_hw_vector: assert property (
      instr_valid_o && flow_i.hw_irq |=>
      pc_o == MMD_HWI_VEC && !instr_valid_o)
      else $error("hw interrupt vector wrong");
   a_sw_vector: assert property (
      instr_valid_o && flow_i.sw_irq && !flow_i.hw_irq |=>
      pc_o == MMD_SWI_VEC)
      else $error("sw interrupt vector wrong");
   a_bubble_one: assert property (
      !instr_valid_o |=> instr_valid_o)
      else $error("bubble longer than one cycle");
   a_stack_depth: assert property (
      depth_r <= 3'(STK_D))
      else $error("stack depth out of range");
   // the pushed value is the pc seen at the call edge, three edges back
   a_call_ret: assert property (
      instr_valid_o && flow_i.call && !flow_i.hw_irq && !flow_i.sw_irq
      ##1 1 ##1 flow_i.ret && !flow_i.hw_irq && !flow_i.sw_irq &&
      !flow_i.call |=> pc_o == $past(pc_o, 3))
      else $error("return address lost");
   a_self_read: assert property (
      dacc_i.rd && rd_self |=> rdata_o == 8'h00)
      else $error("indirect self read not zero");
   a_hole_read: assert property (
      dacc_i.rd && ea == A_HOLE |=> rdata_o == 8'h00)
      else $error("unassigned address not zero");
   a_ptr_ones: assert property (
      dacc_i.rd && !rd_self && ea == A_POINTER |=>
      rdata_o[7:6] == 2'b11)
      else $error("pointer high bits not one");
   a_pin3_low: assert property (
      pin_oe_o[3] |-> !pin_out_o[3])
      else $error("pin 3 driven high");
   a_tmr_ovf: assert property (
      tmr_ovf |=> ifl_r[FL_TOV])
      else $error("timer overflow flag missed");
endmodule

// ---- pkg/mmd_pkg.sv ----
// constants and carrier types for the memory map decode block
package mmd_pkg;
   localparam int PC_W = 10;
   localparam logic [9:0] MMD_RESET_VEC = 10'h3ff;
   localparam logic [9:0] MMD_HWI_VEC = 10'h008;
   localparam logic [9:0] MMD_SWI_VEC = 10'h002;
   localparam int STK_D = 5;
   localparam int PINS = 6;
   localparam int WDT_W = 8;
   // data map
   localparam logic [5:0] A_INDIRECT = 6'h00;
   localparam logic [5:0] A_TIMER = 6'h01;
   localparam logic [5:0] A_PCL = 6'h02;
   localparam logic [5:0] A_STATUS = 6'h03;
   localparam logic [5:0] A_POINTER = 6'h04;
   localparam logic [5:0] A_HOLE = 6'h05;
   localparam logic [5:0] A_PORT = 6'h06;
   localparam logic [5:0] A_BYTE7 = 6'h07;
   localparam logic [5:0] A_PWR = 6'h08;
   localparam logic [5:0] A_WAKE = 6'h09;
   localparam logic [5:0] A_PC_HIGH_BUFFER = 6'h0a;
   localparam logic [5:0] A_PDN = 6'h0b;
   localparam logic [5:0] A_ODR = 6'h0c;
   localparam logic [5:0] A_PUP = 6'h0d;
   localparam logic [5:0] A_IEN = 6'h0e;
   localparam logic [5:0] A_IFL = 6'h0f;
   localparam logic [5:0] A_GPR_LO = 6'h10;
   localparam logic [5:0] A_GPR_HI = 6'h3f;
   localparam logic [5:0] A_DIR_SEL = 6'h06;
   // fixed read patterns of unimplemented bits and the status write mask
   localparam logic [7:0] PTR_ONES = 8'hc0;
   localparam logic [7:0] PWR_ONES = 8'h1f;
   localparam logic [7:0] IEN_ONES = 8'h78;
   localparam logic [7:0] STATUS_WMASK = 8'h87;
   // reset values
   localparam logic [7:0] PWR_RST = 8'ha0;
   localparam logic [7:0] OPT_RST = 8'hff;
   localparam logic [5:0] DIR_RST = 6'h3f;
   localparam logic [7:0] STATUS_RST = 8'h18;
   // timer and ext edge option fields
   localparam int OPT_EDGE = 6;
   localparam int OPT_SRC = 5;
   localparam int OPT_SE = 4;
   localparam int OPT_PSA = 3;
   // other field positions
   localparam int PWR_WDE = 7;
   localparam int PWR_EIS = 6;
   localparam int IEN_GIE = 7;
   localparam int ST_RST = 7;
   localparam int ST_TO = 4;
   localparam int ST_PD = 3;
   localparam int FL_EXT = 2;
   localparam int FL_CHG = 1;
   localparam int FL_TOV = 0;
   // oscillator modes
   localparam logic [1:0] OSC_IRC = 2'h0;
   localparam logic [1:0] OSC_EXTERNAL_RES_OSC = 2'h1;

   typedef enum logic [1:0] {
      MMD_RUN = 2'b01,
      MMD_BUB = 2'b10
   } mmd_ex_t;

   typedef struct packed {
      logic go;
      logic call;
      logic ret;
      logic hw_irq;
      logic sw_irq;
      logic [9:0] target;
   } mmd_flow_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } mmd_dacc_t;
endpackage

// ---- tb/mmd_core_model.sv ----
// behavioural cpu core that offers flow and data requests to the map
`timescale 1ns/10ps
module mmd_core_model
   import mmd_pkg::*;
(
   // clock and bubble indication
   input wire logic core_clk_i,
   input wire logic instr_valid_i,
   // requests to the map
   output mmd_flow_t flow_o,
   output mmd_dacc_t dacc_o
);
   // idle cycles before a data request, to model a slow core
   int gap = 0;

   initial
   begin
      flow_o = '0;
      dacc_o = '0;
   end

   task automatic data(input logic rd, input logic wr, input logic [5:0] a,
                       input logic [7:0] d);
      repeat (gap) @(negedge core_clk_i);
      // nothing is offered in the bubble, a write there would be dropped
      while (!instr_valid_i)
         @(negedge core_clk_i);
      dacc_o = '{rd, wr, a, d};
      @(negedge core_clk_i);
      // a released bus shows inverted values, never the last ones
      dacc_o = '{1'b0, 1'b0, ~a, ~d};
   endtask

   task automatic flow(input int k, input logic [9:0] t);
      while (!instr_valid_i)
         @(negedge core_clk_i);
      flow_o = '{k == 0, k == 1, k == 2, k == 3, k == 4, t};
      @(negedge core_clk_i);
      flow_o = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~t};
   endtask
endmodule

// ---- tb/tb_mmd_core_map.sv ----
// self-checking bench for the core memory map block
`timescale 1ns/10ps
module tb_mmd_core_map;
   import mmd_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   mmd_flow_t flow;
   mmd_dacc_t dacc;
   logic option_load_i = 1'b0;
   logic dir_load_i = 1'b0;
   logic [5:0] dir_sel_i = 6'h00;
   logic sleep_i = 1'b0;
   logic clrwdt_i = 1'b0;
   logic pin3_is_reset_i = 1'b0;
   logic [1:0] osc_mode_i = OSC_IRC;
   logic pin4_clkout_en_i = 1'b0;
   logic wdt_tick_i = 1'b0;
   logic [5:0] pin_in_i = 6'h00;
   logic [9:0] pc_o;
   logic instr_valid_o;
   logic [7:0] rdata_o;
   logic [5:0] pin_out_o;
   logic [5:0] pin_oe_o;
   logic [5:0] pull_up_o;
   logic irq_req_o;
   logic wake_o;
   logic sleeping_o;
   logic wdt_timeout_o;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;

   initial
   begin
      forever
         #12.5 core_clk_i = ~core_clk_i;
   end

   mmd_core_model u_mmd_core_model (
      .core_clk_i(core_clk_i),
      .instr_valid_i(instr_valid_o),
      .flow_o(flow),
      .dacc_o(dacc)
   );

   mmd_core_map u_mmd_core_map (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .flow_i(flow),
      .pc_o(pc_o),
      .instr_valid_o(instr_valid_o),
      .dacc_i(dacc),
      .flags_we_i(1'b0),
      .flags_i(3'h0),
      .rdata_o(rdata_o),
      .option_load_i(option_load_i),
      .dir_load_i(dir_load_i),
      .dir_sel_i(dir_sel_i),
      .sleep_i(sleep_i),
      .clrwdt_i(clrwdt_i),
      .osc_mode_i(osc_mode_i),
      .pin3_is_reset_i(pin3_is_reset_i),
      .pin4_clkout_en_i(pin4_clkout_en_i),
      .wdt_tick_i(wdt_tick_i),
      .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o),
      .pin_oe_o(pin_oe_o),
      .pull_up_o(pull_up_o),
      .pull_down_o(),
      .irq_req_o(irq_req_o),
      .wake_o(wake_o),
      .sleeping_o(sleeping_o),
      .wdt_timeout_o(wdt_timeout_o)
   );

   task automatic test_done();
      if (error_cnt == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // a hang is cut short well past the roughly one thousand cycles needed
   always @(posedge core_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         error_cnt++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [9:0] seen,
                        input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [7:0] ptr_exp(input logic [5:0] a);
      return PTR_ONES | {2'b00, a};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   // an idle edge between transfers keeps each drive change single
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      tick(1);
      u_mmd_core_model.data(1'b0, 1'b1, a, d);
   endtask

   task automatic rdchk(input string what, input logic [5:0] a,
                        input logic [7:0] e);
      tick(1);
      u_mmd_core_model.data(1'b1, 1'b0, a, 8'h00);
      check(what, {2'b00, rdata_o}, {2'b00, e});
   endtask

   // option or direction load through a dedicated instruction strobe
   task automatic special(input logic opt, input logic [7:0] d);
      tick(1);
      option_load_i = opt;
      dir_load_i = !opt;
      dir_sel_i = A_DIR_SEL;
      u_mmd_core_model.data(1'b0, 1'b0, 6'h00, d);
      option_load_i = 1'b0;
      dir_load_i = 1'b0;
   endtask

   task automatic scan(input int n, input bit wd, output logic s);
      s = 1'b0;
      repeat (n)
      begin
         tick(1);
         s |= wd ? wdt_timeout_o : wake_o;
      end
   endtask

   initial
   begin
      logic [9:0] tgt;
      logic [9:0] ret_q [STK_D];
      logic [5:0] a;
      logic [7:0] d;
      logic seen;
      void'($urandom(79));
      tick(10);
      check("pc in reset", pc_o, MMD_RESET_VEC);
      rst_i = 1'b0;
      tick(1);
      check("pc wrap", pc_o, 10'h000);
      tgt = 10'($urandom);
      u_mmd_core_model.flow(0, tgt);
      check("jump target", pc_o, tgt);
      tick(1);
      for (int i = 0; i < STK_D; i++)
      begin
         ret_q[i] = pc_o;
         tgt = (i == 0) ? 10'h3ff : 10'($urandom);
         u_mmd_core_model.flow(1, tgt);
         check("call target", pc_o, tgt);
         check("bubble", {9'h000, instr_valid_o}, 10'h000);
         tick(1);
         check("pc step", pc_o, tgt + 10'h001);
      end
      for (int i = STK_D - 1; i >= 0; i--)
      begin
         u_mmd_core_model.flow(2, 10'h000);
         check("return", pc_o, ret_q[i]);
         tick(1);
      end
      u_mmd_core_model.flow(3, 10'h155);
      check("hw vector", pc_o, MMD_HWI_VEC);
      tick(1);
      u_mmd_core_model.flow(4, 10'h155);
      check("sw vector", pc_o, MMD_SWI_VEC);
      tick(1);
      for (int i = 0; i < 10; i++)
      begin
         a = (i == 0) ? A_BYTE7 : (i == 1) ? A_GPR_LO : (i == 2) ? A_GPR_HI
            : 6'($urandom_range(16, 63));
         d = 8'($urandom);
         u_mmd_core_model.gap = $urandom_range(0, 2);
         wr(a, d);
         wr(A_POINTER, {2'($urandom), a});
         rdchk("indirect read", A_INDIRECT, d);
         rdchk("direct read", a, d);
         rdchk("pointer read", A_POINTER, ptr_exp(a));
      end
      u_mmd_core_model.gap = 0;
      wr(A_HOLE, 8'hff);
      rdchk("hole", A_HOLE, 8'h00);
      wr(A_POINTER, 8'h00);
      wr(A_INDIRECT, 8'h77);
      rdchk("self indirect", A_INDIRECT, 8'h00);
      wr(A_PWR, 8'h80);
      rdchk("power ones", A_PWR, 8'h80 | PWR_ONES);
      wr(A_IEN, 8'h00);
      rdchk("enable ones", A_IEN, IEN_ONES);
      wr(A_PC_HIGH_BUFFER, 8'hff);
      rdchk("pc_high_buffer zeros", A_PC_HIGH_BUFFER, 8'h03);
      wr(A_PCL, 8'h5a);
      check("pcl write", pc_o, {2'b11, 8'h5a});
      check("pcl bubble", {9'h000, instr_valid_o}, 10'h000);
      special(1'b1, 8'h08);
      wr(A_IFL, 8'h00);
      wr(A_TIMER, 8'hfe);
      tick(6);
      rdchk("timer overflow", A_IFL, 8'h01);
      wr(A_IEN, 8'h81);
      tick(2);
      check("irq on", {9'h000, irq_req_o}, 10'h001);
      wr(A_IEN, 8'h01);
      tick(2);
      check("irq masked", {9'h000, irq_req_o}, 10'h000);
      special(1'b1, 8'h28);
      wr(A_TIMER, 8'h00);
      repeat (3)
      begin
         pin_in_i[2] = 1'b1;
         tick(2);
         pin_in_i[2] = 1'b0;
         tick(2);
      end
      rdchk("pin clocked timer", A_TIMER, 8'h03);
      wr(A_ODR, 8'h00);
      wr(A_PORT, 8'h3f);
      special(1'b0, 8'h3d);
      tick(1);
      check("pin enables", {4'h0, pin_oe_o}, 10'h002);
      check("pin1 level", {9'h000, pin_out_o[1]}, 10'h001);
      special(1'b0, 8'h00);
      tick(1);
      check("pin3 high", {9'h000, pin_oe_o[3] & pin_out_o[3]}, 10'h000);
      special(1'b0, 8'h3f);
      wr(A_WAKE, 8'h3f);
      sleep_i = 1'b1;
      tick(1);
      sleep_i = 1'b0;
      tick(2);
      check("asleep", {9'h000, sleeping_o}, 10'h001);
      pin_in_i[1] = 1'b1;
      scan(10, 1'b0, seen);
      check("wake", {9'h000, seen}, 10'h001);
      clrwdt_i = 1'b1;
      tick(1);
      clrwdt_i = 1'b0;
      wdt_tick_i = 1'b1;
      scan(300, 1'b1, seen);
      check("wdt expiry", {9'h000, seen}, 10'h001);
      wdt_tick_i = 1'b0;
      wr(A_PWR, 8'h00);
      wdt_tick_i = 1'b1;
      scan(300, 1'b1, seen);
      check("wdt off", {9'h000, seen}, 10'h000);
      wdt_tick_i = 1'b0;
      pin4_clkout_en_i = 1'b1;
      tick(2);
      check("clock out oe", {9'h000, pin_oe_o[4]}, 10'h001);
      seen = pin_out_o[4];
      tick(1);
      check("clock out", {9'h000, pin_out_o[4]}, {9'h000, ~seen});
      osc_mode_i = OSC_EXTERNAL_RES_OSC;
      special(1'b0, 8'h00);
      tick(1);
      check("pin5 clock in", {9'h000, pin_oe_o[5]}, 10'h000);
      pin3_is_reset_i = 1'b1;
      tick(1);
      check("pin3 reset", pc_o, MMD_RESET_VEC);
      pin_in_i[3] = 1'b1;
      tick(2);
      check("pin3 pull-up", {9'h000, pull_up_o[3]}, 10'h001);
      test_done();
   end
endmodule
